// File: logic/cgen_top.sv
`timescale 1ns/1ps
`include "cgen_cfg.svh"

// Overview of operation
// [R1] main outputs divide source by 1..127
// [R2] odd ratios keep 50 percent duty
// [R3] divisor zero stops divider, output tristated
// [R4] bank bit picks A/B divisor register
// [R5] aux divider: off, /4, /2, /3
// [R6] source select code picks reference or synthesizer
// [R7] buffered reference driven only when enabled
// [R8] pin: shutdown or output enable by function
// [R9] duty trim passed to pad predrivers
// [R10] drive trim passed to pad drivers
// [R11] totals: 2(P+3)+lsb over Q+2
// [R12] programmer picks loop filter by multiplier
// [R13] disabled synthesizer 2/3 outputs get divisor zero
// [R14] synthesizer 1 off turns dependent outputs off
// [R15] load trim passed; zero for external reference
// [R16] programmer sets gain for external reference
// [R17] programmer sets gain for crystal
// [R18] reserved bits written zero, read zero
// [R19] divisor writes act at once, unsynchronised
// [R20] each byte takes effect when accepted
// [R21] programmer updates inactive set then switches
// [R22] register bus works during shutdown
// [R23] select-pin divisor switch is glitch free
// [R24] select pins 1,0 latched after reset
module cgen_top
    import cgen_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // select and shutdown pins
    input wire logic freq_select_2,
    input wire logic freq_select_1,
    input wire logic freq_select_0,
    input wire logic shutdown_oe_pin,
    // clock sources, as sampled levels
    input wire logic ref_clk_lvl,
    input wire logic synthesizer_1_lvl,
    input wire logic synthesizer_2_lvl,
    input wire logic synthesizer_3_lvl,
    // clock outputs: 0..3 output_a..d, 4 aux_output, 5 buffered reference
    output logic [5:0] clk_out,
    output logic [5:0] clk_oe,
    output logic [5:0][1:0] duty_trim,
    output logic [5:0][1:0] drive_trim,
    // synthesizer and oscillator controls
    output logic [2:0] synth_run,
    output logic [2:0][11:0] mult_total,
    output logic [2:0][8:0] div_total,
    output logic [2:0][2:0] loop_filter_select,
    output logic [5:0] crystal_load_trim,
    output logic [1:0] oscillator_gain,
    output logic osc_run
);
    localparam int N_MAIN = 4;
    localparam int N_DIV = 5;

    cgen_main_s st_r;
    cgen_main_s st_nxt;

    logic [N_DIV-1:0] div_src;
    logic [N_DIV-1:0] div_run;
    logic [N_DIV-1:0][6:0] div_val;
    logic [N_DIV-1:0] div_lvl;
    logic [N_DIV-1:0] div_wrap;

    cgen_div_if dif[N_DIV] ();

    genvar g;
    generate
        for (g = 0; g < N_DIV; g++) begin : g_div
            assign dif[g].src = div_src[g];
            assign dif[g].run = div_run[g];
            assign dif[g].div = div_val[g];
            assign div_lvl[g] = dif[g].clk_lvl;
            assign div_wrap[g] = dif[g].wrap;
            cgen_out_div u_div (
                .aclk(aclk),
                .aresetn(aresetn),
                .dif(dif[g])
            );
        end
    endgenerate

    // ==========
    // helpers
    function automatic cgen_word_t cg_merge(input cgen_word_t old, input cgen_word_t d,
                                            input logic [3:0] s, input cgen_word_t m);
        cgen_word_t r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r & m; // [R18]
    endfunction : cg_merge

    // reserved code 001 yields no source
    function automatic logic cg_src(input logic [2:0] fs, input logic r, input logic s1,
                                    input logic s2, input logic s3);
        logic v;
        unique case (fs[2:1])
            `CG_FS_REFGRP: v = r & ~fs[0];
            `CG_FS_SYN1: v = s1 ^ fs[0];
            `CG_FS_SYN2: v = s2 ^ fs[0];
            default: v = s3 ^ fs[0];
        endcase
        return v; // [R6]
    endfunction : cg_src

    // ==========
    // combinational next state
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic have_aw;
    logic have_w;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [2:0] row;
    cgen_word_t syn1;
    cgen_word_t sw;
    logic syn1_en;
    logic full_sd;
    logic pin_on;
    logic [2:0] fs;
    logic [6:0] dv;
    logic [11:0] pp;
    logic [1:0] wresp;
    logic [1:0] rresp;
    cgen_word_t rd;

    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;

    always_comb begin
        st_nxt = st_r;
        aw_hs = s_axi_awvalid && s_axi_awready;
        w_hs = s_axi_wvalid && s_axi_wready;
        ar_hs = s_axi_arvalid && s_axi_arready;
        have_aw = st_r.aw_got || aw_hs;
        have_w = st_r.w_got || w_hs;
        wa = st_r.aw_got ? st_r.aw_addr : s_axi_awaddr;
        wd = st_r.w_got ? st_r.w_data : s_axi_wdata;
        ws = st_r.w_got ? st_r.w_strb : s_axi_wstrb;
        wresp = `CG_RESP_OKAY;
        rresp = `CG_RESP_OKAY;
        rd = '0;

        // select pins 1 and 0 are caught once after reset
        if (!st_r.strap_done) begin
            st_nxt.strap = {freq_select_1, freq_select_0}; // [R24]
            st_nxt.strap_done = 1'b1;
        end
        row = {freq_select_2, st_r.strap}; // [R24]
        syn1 = st_r.syn1_w[row];
        syn1_en = syn1[`CG_EN_BIT];
        full_sd = st_r.misc_w[`CG_PDN_FN_BIT] && !shutdown_oe_pin; // [R8]
        pin_on = shutdown_oe_pin; // [R8]

        // main outputs
        for (int i = 0; i < N_MAIN; i++) begin
            fs = st_r.out_w[i][`CG_FS_LSB +: 3];
            if (i < 2 && st_r.bank_app[i]) begin
                dv = st_r.out_w[i][`CG_DIV1_LSB +: 7]; // [R4]
            end else begin
                dv = st_r.out_w[i][`CG_DIV0_LSB +: 7];
            end
            div_val[i] = dv; // [R1] [R19]
            div_src[i] = cg_src(fs, ref_clk_lvl, synthesizer_1_lvl, synthesizer_2_lvl,
                                synthesizer_3_lvl); // [R6]
            div_run[i] = !full_sd && !(fs[2:1] == `CG_FS_SYN1 && !syn1_en); // [R14]
            st_nxt.oe[i] = div_run[i] && pin_on && dv != 7'h00; // [R3]
            duty_trim[i] = st_r.out_w[i][`CG_DUTY_LSB +: 2]; // [R9]
            drive_trim[i] = st_r.out_w[i][`CG_DRIVE_LSB +: 2]; // [R10]
        end

        // bank change from the select pins waits for a period end of its output, or applies at once while that output is off
        for (int i = 0; i < 2; i++) begin
            if (div_wrap[i] || !st_r.oe[i]) begin
                st_nxt.bank_app[i] = syn1[`CG_BANK_BIT]; // [R23] [R4]
            end
        end

        // aux output from synthesizer 1 zero phase
        unique case (st_r.misc_w[`CG_AUXDIV_LSB +: 2])
            `CG_AUX_OFF: div_val[4] = 7'h00;
            `CG_AUX_D4: div_val[4] = `CG_DIV_BY4;
            `CG_AUX_D2: div_val[4] = `CG_DIV_BY2;
            default: div_val[4] = `CG_DIV_BY3;
        endcase // [R5]
        div_src[4] = synthesizer_1_lvl;
        div_run[4] = !full_sd && syn1_en; // [R14]
        st_nxt.oe[4] = div_run[4] && pin_on && div_val[4] != 7'h00; // [R5]
        duty_trim[4] = st_r.misc_w[`CG_AUX_DUTY_LSB +: 2]; // [R9]
        drive_trim[4] = st_r.misc_w[`CG_AUX_DRIVE_LSB +: 2]; // [R10]

        // buffered reference
        st_nxt.xbuf_lvl = ref_clk_lvl && !full_sd;
        st_nxt.oe[5] = st_r.misc_w[`CG_XBUF_OE_BIT] && pin_on && !full_sd; // [R7]
        duty_trim[5] = st_r.misc_w[`CG_XBUF_DUTY_LSB +: 2]; // [R9]
        drive_trim[5] = st_r.misc_w[`CG_XBUF_DRIVE_LSB +: 2]; // [R10]

        // synthesizer controls; settings follow each accepted byte at once
        for (int k = 0; k < 3; k++) begin
            sw = (k == 0) ? syn1 : st_r.syn23_w[k-1];
            pp = {2'h0, sw[`CG_P_LSB +: 10]} + `CG_P_OFFSET;
            st_nxt.mt[k] = {pp[10:0], 1'b0} + {11'h000, sw[`CG_P0_BIT]}; // [R11]
            st_nxt.qt[k] = {1'b0, sw[`CG_Q_LSB +: 8]} + `CG_Q_OFFSET; // [R11]
            st_nxt.lf[k] = sw[`CG_LF_LSB +: 3]; // [R12]
            // outputs on a stopped synthesizer 2/3 rely on the divisor being zero
            st_nxt.syn_run[k] = sw[`CG_EN_BIT] && !full_sd; // [R13]
        end
        st_nxt.osc_run = !full_sd; // [R8]

        // ==========
        // register write: bus stays live whatever the shutdown pin does
        if (aw_hs) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (w_hs) begin
            st_nxt.w_got = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (have_aw && have_w) begin // [R22]
            if (wa >= `CG_OFS_OUT0 && wa < `CG_OFS_OUT0 + `CG_OUT_SPAN) begin
                st_nxt.out_w[wa[3:2]] = cg_merge(st_r.out_w[wa[3:2]], wd, ws,
                                                 `CG_OUT_MASK); // [R20] [R19]
            end else if (wa[7:2] == `CG_OFS_MISC >> 2) begin
                st_nxt.misc_w = cg_merge(st_r.misc_w, wd, ws, `CG_MISC_MASK); // [R20] [R15]
            end else if (wa[7:2] == `CG_OFS_SYN2 >> 2) begin
                st_nxt.syn23_w[0] = cg_merge(st_r.syn23_w[0], wd, ws, `CG_SYN23_MASK); // [R20]
            end else if (wa[7:2] == `CG_OFS_SYN3 >> 2) begin
                st_nxt.syn23_w[1] = cg_merge(st_r.syn23_w[1], wd, ws, `CG_SYN23_MASK); // [R20]
            end else if (wa >= `CG_OFS_SYN1 && wa < `CG_OFS_SYN1 + `CG_SYN1_SPAN) begin
                st_nxt.syn1_w[wa[4:2]] = cg_merge(st_r.syn1_w[wa[4:2]], wd, ws,
                                                  `CG_SYN1_MASK); // [R20] [R21]
            end else if (wa[7:2] != `CG_OFS_STATUS >> 2) begin
                wresp = `CG_RESP_SLVERR;
            end
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wresp;
        end

        // ==========
        // register read
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (ar_hs) begin // [R22]
            if (s_axi_araddr >= `CG_OFS_OUT0 && s_axi_araddr < `CG_OFS_OUT0 + `CG_OUT_SPAN) begin
                rd = st_r.out_w[s_axi_araddr[3:2]];
            end else if (s_axi_araddr[7:2] == `CG_OFS_MISC >> 2) begin
                rd = st_r.misc_w;
            end else if (s_axi_araddr[7:2] == `CG_OFS_SYN2 >> 2) begin
                rd = st_r.syn23_w[0];
            end else if (s_axi_araddr[7:2] == `CG_OFS_SYN3 >> 2) begin
                rd = st_r.syn23_w[1];
            end else if (s_axi_araddr >= `CG_OFS_SYN1
                         && s_axi_araddr < `CG_OFS_SYN1 + `CG_SYN1_SPAN) begin
                rd = st_r.syn1_w[s_axi_araddr[4:2]];
            end else if (s_axi_araddr[7:2] == `CG_OFS_STATUS >> 2) begin
                rd[`CG_ST_ROW_LSB +: 3] = row;
                rd[`CG_ST_BANK_LSB +: 2] = st_r.bank_app;
                rd[`CG_ST_SD_BIT] = full_sd;
                rd[`CG_ST_OE_LSB +: 6] = st_r.oe;
                rd[`CG_ST_RUN_LSB +: 3] = st_r.syn_run;
            end else begin
                rresp = `CG_RESP_SLVERR;
            end
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd;
            st_nxt.rresp = rresp;
        end
    end

    // ==========
    // state register; all zero matches a blank device with outputs off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========
    // outputs
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign clk_out = {st_r.xbuf_lvl, div_lvl}; // [R2]
    assign clk_oe = st_r.oe; // [R3] [R7]
    assign synth_run = st_r.syn_run;
    assign mult_total = st_r.mt;
    assign div_total = st_r.qt;
    assign loop_filter_select = st_r.lf;
    assign crystal_load_trim = st_r.misc_w[`CG_LOAD_LSB +: 6]; // [R15]
    assign oscillator_gain = st_r.misc_w[`CG_GAIN_LSB +: 2]; // [R16] [R17]
    assign osc_run = st_r.osc_run;
endmodule : cgen_top

// File: logic/cgen_cfg.svh
`ifndef CGEN_CFG_SVH
`define CGEN_CFG_SVH

// ==========
// register byte offsets
`define CG_OFS_OUT0 8'h00
`define CG_OUT_SPAN 8'h10
`define CG_OFS_MISC 8'h10
`define CG_OFS_SYN2 8'h14
`define CG_OFS_SYN3 8'h18
`define CG_OFS_SYN1 8'h20
`define CG_SYN1_SPAN 8'h20
`define CG_OFS_STATUS 8'h40

// ==========
// output word fields
`define CG_DIV0_LSB 0
`define CG_DIV1_LSB 8
`define CG_FS_LSB 16
`define CG_DUTY_LSB 20
`define CG_DRIVE_LSB 22
`define CG_OUT_MASK 32'h00F7_7F7F

// ==========
// misc word fields
`define CG_AUXDIV_LSB 0
`define CG_XBUF_OE_BIT 2
`define CG_PDN_FN_BIT 3
`define CG_AUX_DUTY_LSB 4
`define CG_AUX_DRIVE_LSB 6
`define CG_XBUF_DUTY_LSB 8
`define CG_XBUF_DRIVE_LSB 10
`define CG_LOAD_LSB 16
`define CG_GAIN_LSB 24
`define CG_MISC_MASK 32'h033F_0FFF

// ==========
// synthesizer word fields
`define CG_Q_LSB 0
`define CG_P_LSB 8
`define CG_P0_BIT 18
`define CG_LF_LSB 19
`define CG_EN_BIT 22
`define CG_BANK_BIT 23
`define CG_SYN1_MASK 32'h00FF_FFFF
`define CG_SYN23_MASK 32'h007F_FFFF
`define CG_P_OFFSET 12'h003
`define CG_Q_OFFSET 9'h002

// ==========
// status word fields
`define CG_ST_ROW_LSB 0
`define CG_ST_BANK_LSB 3
`define CG_ST_SD_BIT 5
`define CG_ST_OE_LSB 6
`define CG_ST_RUN_LSB 12

// ==========
// decodes and answers
`define CG_AUX_OFF 2'h0
`define CG_AUX_D4 2'h1
`define CG_AUX_D2 2'h2
`define CG_DIV_BY4 7'h04
`define CG_DIV_BY2 7'h02
`define CG_DIV_BY3 7'h03
`define CG_FS_SYN1 2'h1
`define CG_FS_SYN2 2'h2
`define CG_FS_REFGRP 2'h0
`define CG_RESP_OKAY 2'h0
`define CG_RESP_SLVERR 2'h2

`endif

// File: logic/cgen_pkg.sv
package cgen_pkg;
    typedef logic [31:0] cgen_word_t;

    typedef struct packed {
        logic src_prev;
        logic [6:0] cnt;
        logic lvl;
        logic wrap;
    } cgen_div_s;

    typedef struct packed {
        logic [3:0][31:0] out_w;
        logic [31:0] misc_w;
        logic [1:0][31:0] syn23_w;
        logic [7:0][31:0] syn1_w;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic strap_done;
        logic [1:0] strap;
        logic [1:0] bank_app;
        logic [5:0] oe;
        logic xbuf_lvl;
        logic [2:0] syn_run;
        logic [2:0][11:0] mt;
        logic [2:0][8:0] qt;
        logic [2:0][2:0] lf;
        logic osc_run;
    } cgen_main_s;
endpackage : cgen_pkg

// File: logic/cgen_div_if.sv
`timescale 1ns/1ps
interface cgen_div_if;
    logic src;
    logic run;
    logic [6:0] div;
    logic clk_lvl;
    logic wrap;
    modport ctrl (output src, output run, output div, input clk_lvl, input wrap);
    modport unit (input src, input run, input div, output clk_lvl, output wrap);
endinterface : cgen_div_if

// File: logic/cgen_out_div.sv
`timescale 1ns/1ps
module cgen_out_div
    import cgen_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // divider channel
    cgen_div_if.unit dif
);
    cgen_div_s st_r;
    cgen_div_s st_nxt;

    // counting both source edges and toggling every div edges gives 50% duty
    // even for odd ratios
    always_comb begin
        st_nxt = st_r;
        st_nxt.wrap = 1'b0;
        st_nxt.src_prev = dif.src;
        if (!dif.run || dif.div == 7'h00) begin
            st_nxt.cnt = 7'h00;
            st_nxt.lvl = 1'b0;
        end else if (dif.src != st_r.src_prev) begin
            // >= so a live shrink of div cannot run the count away
            if ({1'b0, st_r.cnt} + 8'h01 >= {1'b0, dif.div}) begin
                st_nxt.cnt = 7'h00;
                st_nxt.lvl = ~st_r.lvl;
                st_nxt.wrap = st_r.lvl;
            end else begin
                st_nxt.cnt = st_r.cnt + 7'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dif.clk_lvl = st_r.lvl;
    assign dif.wrap = st_r.wrap;
endmodule : cgen_out_div

// File: verification/cgen_top_properties.sv
`timescale 1ns/1ps
// ========
// bus and output properties of cgen_top
module cgen_top_properties (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // register bus
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // pins and outputs
    input logic shutdown_oe_pin,
    input logic [5:0] clk_oe,
    input logic [5:0][1:0] duty_trim,
    input logic [5:0][1:0] drive_trim,
    input logic [5:0] crystal_load_trim
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    a_ar_ready: assert property (
        s_axi_arready != s_axi_rvalid)
        else $error("read address ready wrong");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_aw_refuse: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_bresp_code: assert property (
        s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
        else $error("write response code illegal");
    a_oe_shut: assert property (
        !shutdown_oe_pin |=> clk_oe == 6'h00)
        else $error("outputs driven with pin low");
    // trims may only move on the cycle a write lands
    a_trim_write: assert property (
        $changed(duty_trim) || $changed(drive_trim) || $changed(crystal_load_trim)
        |-> $rose(s_axi_bvalid))
        else $error("trim changed without write");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_shut: cover property (!shutdown_oe_pin ##1 !shutdown_oe_pin);
endmodule : cgen_top_properties

// File: verification/cgen_axi_model.sv
`timescale 1ns/1ps
// ========
// register programmer: one write and one read at a time
module cgen_axi_model (
    // clock
    input logic aclk,
    // write channels
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    output logic s_axi_bready,
    // read channels
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    // each byte lands on acceptance, so a call returns only after the answer
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            output logic [1:0] r);
        logic ha, hw, hb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end while (!hb);
        s_axi_bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : cgen_axi_model

// File: verification/cgen_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module cgen_top_tb;
    logic aclk, aresetn, osc_run;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, synth_run;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb, lv = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, oscillator_gain, rsp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, shutdown_oe_pin;
    logic freq_select_2, freq_select_1, freq_select_0;
    logic ref_clk_lvl, synthesizer_1_lvl, synthesizer_2_lvl, synthesizer_3_lvl;
    logic [5:0] clk_out, clk_oe, crystal_load_trim;
    logic [5:0][1:0] duty_trim, drive_trim;
    logic [2:0][11:0] mult_total;
    logic [2:0][8:0] div_total;
    logic [2:0][2:0] loop_filter_select;
    int sc[4], cyc, bad_count, tests_run, r, h;
    // source half periods in cycles: ref 2, synthesizers 3, 4, 5
    localparam int HALF[4] = '{2, 3, 4, 5};
    localparam int EXP_SRC[8] = '{90, 0, 60, 60, 45, 45, 36, 36};
    localparam int EXP_AUX[4] = '{0, 15, 30, 20};

    assign {synthesizer_3_lvl, synthesizer_2_lvl, synthesizer_1_lvl, ref_clk_lvl} = lv;

    cgen_top dut (.*);
    cgen_axi_model pm (.*);

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        for (int i = 0; i < 4; i++) begin
            sc[i] <= (sc[i] == HALF[i] - 1) ? 0 : sc[i] + 1;
            lv[i] <= lv[i] ^ (sc[i] == HALF[i] - 1);
        end
    end

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            finish_test();
        end
    end

    // ========
    // helpers
    task idle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : idle

    task w(input logic [7:0] a, input logic [31:0] d);
        pm.wr(a, d, 4'hF, rsp);
        idle(2);
    endtask : w

    // window of 360 cycles is a whole number of every expected period
    task meas(input int i);
        logic p;
        r = 0;
        h = 0;
        idle(40);
        p = clk_out[i];
        repeat (360) begin
            idle(1);
            if (clk_out[i] && !p) r++;
            if (clk_out[i]) h++;
            p = clk_out[i];
        end
    endtask : meas

    // ========
    // scenarios
    task t_bus;
        pm.wr(8'h00, 32'hFFFF_FFFF, 4'hF, rsp);
        pm.rd(8'h00, rdat, rsp);
        `CHK(rdat, 32'h00F7_7F7F);
        pm.rd(8'h44, rdat, rsp);
        `CHK(rsp, 2'h2);
        `CHK(rdat, 32'h0000_0000);
        pm.wr(8'h48, 32'h0000_0001, 4'hF, rsp);
        `CHK(rsp, 2'h2);
        w(8'h00, 32'h0);
        $display("test bus done");
    endtask : t_bus

    task t_div;
        w(8'h08, 32'h00E0_0003);
        `CHK(duty_trim[2], 2'h2);
        `CHK(drive_trim[2], 2'h3);
        meas(2);
        `CHK(clk_oe[2], 1'b1);
        `CHK(r, 30);
        `CHK(h, 180);
        w(8'h08, 32'h0);
        `CHK(clk_oe[2], 1'b0);
        $display("test divider done");
    endtask : t_div

    task t_src;
        w(8'h20, 32'h0040_0000);
        w(8'h14, 32'h0040_0000);
        w(8'h18, 32'h0040_0000);
        for (int c = 0; c < 8; c++) begin
            w(8'h0C, 32'h1 | 32'(c << 16));
            meas(3);
            `CHK(r, EXP_SRC[c]);
        end
        $display("test source done");
    endtask : t_src

    task t_aux;
        for (int c = 1; c < 4; c++) begin
            w(8'h10, 32'(c));
            meas(4);
            `CHK(r, EXP_AUX[c]);
        end
        w(8'h10, 32'h0);
        `CHK(clk_oe[4], 1'b0);
        w(8'h10, 32'h1);
        w(8'h0C, 32'h0002_0001);
        `CHK(clk_oe[4:3], 2'h3);
        w(8'h20, 32'h0);
        `CHK(clk_oe[4:3], 2'h0);
        `CHK(synth_run[0], 1'b0);
        w(8'h10, 32'h0);
        w(8'h0C, 32'h0);
        $display("test aux done");
    endtask : t_aux

    task t_bank;
        w(8'h00, 32'h0000_0201);
        w(8'h20, 32'h00C0_0000);
        meas(0);
        `CHK(r, 45);
        w(8'h30, 32'h0040_0000);
        @(posedge aclk);
        freq_select_2 <= 1'b1;
        freq_select_0 <= 1'b1;
        meas(0);
        `CHK(r, 90);
        pm.rd(8'h40, rdat, rsp);
        `CHK(rdat[2:0], 3'h4);
        @(posedge aclk);
        freq_select_2 <= 1'b0;
        $display("test bank done");
    endtask : t_bank

    task t_synth;
        w(8'h14, 32'h0);
        w(8'h14, 32'h000C_FF05);
        `CHK(mult_total[1], 12'h205);
        `CHK(div_total[1], 9'h007);
        `CHK(loop_filter_select[1], 3'h1);
        pm.wr(8'h14, 32'h0000_00FF, 4'h1, rsp);
        idle(2);
        `CHK(div_total[1], 9'h101);
        `CHK(mult_total[1], 12'h205);
        w(8'h10, 32'h022A_0000);
        `CHK(crystal_load_trim, 6'h2A);
        `CHK(oscillator_gain, 2'h2);
        w(8'h10, 32'h0);
        $display("test synth done");
    endtask : t_synth

    task t_shut;
        w(8'h10, 32'h4);
        `CHK(clk_oe[5], 1'b1);
        meas(5);
        `CHK(r, 90);
        w(8'h10, 32'h0);
        `CHK(clk_oe[5], 1'b0);
        w(8'h08, 32'h0000_0001);
        @(posedge aclk);
        shutdown_oe_pin <= 1'b0;
        idle(3);
        `CHK(clk_oe, 6'h00);
        `CHK(synth_run[0], 1'b1);
        `CHK(osc_run, 1'b1);
        pm.rd(8'h08, rdat, rsp);
        `CHK(rdat, 32'h0000_0001);
        w(8'h10, 32'h8);
        `CHK(synth_run, 3'h0);
        `CHK(osc_run, 1'b0);
        @(posedge aclk);
        shutdown_oe_pin <= 1'b1;
        idle(3);
        `CHK(osc_run, 1'b1);
        `CHK(clk_oe[2], 1'b1);
        $display("test shutdown done");
    endtask : t_shut

    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    initial begin
        aresetn = 1'b0;
        shutdown_oe_pin = 1'b1;
        freq_select_2 = 1'b0;
        freq_select_1 = 1'b0;
        freq_select_0 = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_bus;
        t_div;
        t_src;
        t_aux;
        t_bank;
        t_synth;
        t_shut;
        finish_test;
    end
endmodule : cgen_top_tb

bind cgen_top cgen_top_properties u_props (.*);
